// File: src/rps_pkg.sv
// constants for the regulator protection and soft-start sequencer
package rps_pkg;
   // phase-clock cycle counts
   localparam logic [10:0] SS_LAST = 11'h7ff;      // 2048 cycles of soft-start
   localparam logic [10:0] SS_HIZ_END = 11'h020;   // first 32 cycles floated
   localparam logic [10:0] SS_LOW_CYC = 11'h096;   // 150 cycles clamped low
   localparam logic [10:0] SS_PULSE_START = SS_HIZ_END + SS_LOW_CYC;
   localparam logic [10:0] OC_WAIT_LAST = 11'h7ff; // 2048-cycle hiccup wait
   // voltage code
   localparam logic [4:0] CODE_OFF = 5'h1f;        // shutdown code
   localparam logic [6:0] REF_TOP_UNITS = 7'h4a;   // 1.850 V in 25 mV units at code 0
   localparam int STEP_MV = 25;
   localparam logic [6:0] REF_STEP = 7'h01;        // one STEP_MV step
   localparam logic [7:0] DUTY_MAX = 8'hff;
   localparam logic [2:0] PH_ALL = 3'h7;
   localparam logic [2:0] PH_NONE = 3'h0;

   // gray codes along off -> soft-start -> run -> hiccup -> ov latch
   typedef enum logic [2:0] {
      RPS_OFF = 3'b000,
      RPS_SS = 3'b001,
      RPS_RUN = 3'b011,
      RPS_OCW = 3'b010,
      RPS_OVL = 3'b110
   } rps_state_t;
endpackage

// File: src/rps_sequencer.sv
// sequencing, protection and reference stepping for a multi-phase buck controller
`timescale 1ns/1ns
// Operation
// - output above 115% of reference forces all phase outputs low at once
// - during overvoltage, output back at reference floats all phase outputs
// - each recurring overvoltage drives all phase outputs low again
// - any overvoltage latches off pulsing until supply power is cycled
// - output more than 18% low drops power good, unlatched, nothing else
// - supply below power-on threshold holds all phase outputs floating
// - supply good, enable above 1.23V and code not shutdown start soft-start
// - code 11111 shuts down; any other code restarts
// - first 32 soft-start cycles: reference inhibited, phase outputs floating
// - from cycle 33, phase outputs held low about 150 cycles
// - then pulsing enabled with duty widened from zero to operating width
// - reference ramps from zero to programmed value at oscillator-set rate
// - soft-start timed by 11-bit phase-clock counter, 2048 cycles long
// - power good never asserted before the 2048th soft-start cycle
// - voltage code sampled at start of each phase-1 cycle; loaded every clock while off or in hiccup wait
// - code stable one more cycle moves reference 25mV per two cycles
// - overcurrent floats outputs, waits 2048 cycles, retries soft-start
// - code decodes 1.100V at 11110 to 1.850V at 00000, 25mV per step
module rps_sequencer
   import rps_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_phase_pulse,
   input wire logic i_por_ok,
   input wire logic i_en_ok,
   input wire logic [4:0] i_voltage_code,
   input wire logic i_ov_cmp,
   input wire logic i_ov_clear,
   input wire logic i_uv_cmp,
   input wire logic i_oc_cmp,
   input wire logic [2:0] i_pwm_cmd,
   output logic [2:0] o_phase_out,
   output logic [2:0] o_phase_oe,
   output logic o_power_good_flag,
   output logic o_dac_en,
   output logic [6:0] o_ref_units,
   output logic [7:0] o_duty_limit
);
   rps_state_t state_r, state_nxt;
   logic [10:0] cnt_r, cnt_nxt;
   logic ov_lat_r, ov_lat_nxt;
   logic ov_low_r, ov_low_nxt;
   logic [4:0] cur_code_r, cur_code_nxt;
   logic [4:0] cand_r, cand_nxt;
   logic cand_v_r, cand_v_nxt;
   logic [6:0] ref_r, ref_nxt;
   logic step_ph_r, step_ph_nxt;
   logic [7:0] duty_r, duty_nxt;
   logic pg_r, pg_nxt;
   logic en_all;
   logic dac_on;
   logic [6:0] tgt_units;

   // shutdown code is checked live so a shutdown is not delayed by sampling
   assign en_all = i_por_ok && i_en_ok && (i_voltage_code != CODE_OFF);
   assign dac_on = (state_r == RPS_RUN) || (state_r == RPS_SS && cnt_r >= SS_HIZ_END);
   assign tgt_units = REF_TOP_UNITS - {2'b00, cur_code_r};

   // sequencing and protection state
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      ov_lat_nxt = ov_lat_r;
      ov_low_nxt = ov_low_r;
      if (!i_por_ok) begin
         state_nxt = RPS_OFF;
         cnt_nxt = 11'h000;
         ov_lat_nxt = 1'b0;
         ov_low_nxt = 1'b0;
      end else if (ov_lat_r || i_ov_cmp) begin
         state_nxt = RPS_OVL;
         ov_lat_nxt = 1'b1;
         if (i_ov_cmp) begin
            ov_low_nxt = 1'b1;
         end else if (i_ov_clear) begin
            ov_low_nxt = 1'b0;
         end
      end else begin
         case (state_r)
            RPS_OFF: begin
               cnt_nxt = 11'h000;
               if (en_all) begin
                  state_nxt = RPS_SS;
               end
            end
            RPS_SS: begin
               if (!en_all) begin
                  state_nxt = RPS_OFF;
                  cnt_nxt = 11'h000;
               end else if (i_oc_cmp) begin
                  state_nxt = RPS_OCW;
                  cnt_nxt = 11'h000;
               end else if (i_phase_pulse) begin
                  cnt_nxt = cnt_r + 11'h001;
                  if (cnt_r == SS_LAST) begin
                     state_nxt = RPS_RUN;
                  end
               end
            end
            RPS_RUN: begin
               cnt_nxt = 11'h000;
               if (!en_all) begin
                  state_nxt = RPS_OFF;
               end else if (i_oc_cmp) begin
                  state_nxt = RPS_OCW;
               end
            end
            RPS_OCW: begin
               if (!en_all) begin
                  state_nxt = RPS_OFF;
                  cnt_nxt = 11'h000;
               end else if (i_phase_pulse) begin
                  cnt_nxt = cnt_r + 11'h001;
                  if (cnt_r == OC_WAIT_LAST) begin
                     state_nxt = RPS_SS;
                  end
               end
            end
            default: begin
               state_nxt = RPS_OFF;
               cnt_nxt = 11'h000;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= RPS_OFF;
         cnt_r <= 11'h000;
         ov_lat_r <= 1'b0;
         ov_low_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         ov_lat_r <= ov_lat_nxt;
         ov_low_r <= ov_low_nxt;
      end
   end

   // phase outputs stay combinational so the overvoltage clamp is not a cycle late
   always_comb begin
      o_phase_out = PH_NONE;
      o_phase_oe = PH_NONE;
      if (!i_por_ok) begin
         o_phase_oe = PH_NONE;
      end else if (i_ov_cmp || (state_r == RPS_OVL && ov_low_r)) begin
         o_phase_oe = PH_ALL;
      end else if (state_r == RPS_SS) begin
         if (cnt_r < SS_HIZ_END) begin
            o_phase_oe = PH_NONE;
         end else if (cnt_r < SS_PULSE_START) begin
            o_phase_oe = PH_ALL;
         end else begin
            o_phase_oe = PH_ALL;
            o_phase_out = i_pwm_cmd;
         end
      end else if (state_r == RPS_RUN) begin
         o_phase_oe = PH_ALL;
         o_phase_out = i_pwm_cmd;
      end
   end

   // voltage code qualification, reference stepping, duty ramp and power good
   always_comb begin
      cur_code_nxt = cur_code_r;
      cand_nxt = cand_r;
      cand_v_nxt = cand_v_r;
      ref_nxt = ref_r;
      step_ph_nxt = step_ph_r;
      duty_nxt = duty_r;
      // drop power good as the state leaves run, so a fault never shows a stale high
      pg_nxt = (state_r == RPS_RUN) && (state_nxt == RPS_RUN) && !i_uv_cmp;
      if (state_r == RPS_OFF || state_r == RPS_OCW) begin
         cur_code_nxt = i_voltage_code;
         cand_v_nxt = 1'b0;
      end else if (i_phase_pulse) begin
         if (!cand_v_r) begin
            if (i_voltage_code != cur_code_r) begin
               cand_nxt = i_voltage_code;
               cand_v_nxt = 1'b1;
            end
         end else if (i_voltage_code == cand_r) begin
            cur_code_nxt = cand_r;
            cand_v_nxt = 1'b0;
         end else if (i_voltage_code == cur_code_r) begin
            cand_v_nxt = 1'b0;
         end else begin
            cand_nxt = i_voltage_code;
         end
      end
      if (!dac_on) begin
         ref_nxt = 7'h00;
         step_ph_nxt = 1'b0;
      end else if (i_phase_pulse) begin
         step_ph_nxt = !step_ph_r;
         // the soft-start ramp and live code changes share one stepper
         if (step_ph_r) begin
            if (ref_r < tgt_units) begin
               ref_nxt = ref_r + REF_STEP;
            end else if (ref_r > tgt_units) begin
               ref_nxt = ref_r - REF_STEP;
            end
         end
      end
      if (state_r == RPS_RUN) begin
         duty_nxt = DUTY_MAX;
      end else if (state_r != RPS_SS || cnt_r < SS_PULSE_START) begin
         duty_nxt = 8'h00;
      end else if (i_phase_pulse && duty_r != DUTY_MAX) begin
         duty_nxt = duty_r + 8'h01;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         cur_code_r <= CODE_OFF;
         cand_r <= CODE_OFF;
         cand_v_r <= 1'b0;
         ref_r <= 7'h00;
         step_ph_r <= 1'b0;
         duty_r <= 8'h00;
         pg_r <= 1'b0;
      end else begin
         cur_code_r <= cur_code_nxt;
         cand_r <= cand_nxt;
         cand_v_r <= cand_v_nxt;
         ref_r <= ref_nxt;
         step_ph_r <= step_ph_nxt;
         duty_r <= duty_nxt;
         pg_r <= pg_nxt;
      end
   end

   assign o_power_good_flag = pg_r;
   assign o_dac_en = dac_on;
   assign o_ref_units = ref_r;
   assign o_duty_limit = duty_r;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   a_ov_forces_low: assert property (
      i_por_ok && i_ov_cmp |-> o_phase_oe == PH_ALL && o_phase_out == PH_NONE)
      else $error("overvoltage did not force phases low");
   a_ov_release_hiz: assert property (
      i_por_ok && state_r == RPS_OVL && !i_ov_cmp && i_ov_clear
      ##1 i_por_ok && !i_ov_cmp |-> o_phase_oe == PH_NONE)
      else $error("phases not floated after overvoltage cleared");
   a_ov_repeat_low: assert property (
      i_por_ok && state_r == RPS_OVL && $rose(i_ov_cmp)
      ##1 i_por_ok |-> ov_low_r && o_phase_oe == PH_ALL)
      else $error("recurring overvoltage not clamped low");
   a_ov_latch_hold: assert property (
      i_por_ok && (ov_lat_r || i_ov_cmp) |=> state_r == RPS_OVL && !o_power_good_flag)
      else $error("overvoltage latch released without power cycle");
   a_uv_drops_pg: assert property (
      i_uv_cmp |=> !o_power_good_flag)
      else $error("power good high during undervoltage");
   a_por_hiz: assert property (
      !i_por_ok |-> o_phase_oe == PH_NONE ##1 state_r == RPS_OFF)
      else $error("phases driven while supply below threshold");
   a_start_ss: assert property (
      state_r == RPS_OFF && en_all && !i_ov_cmp && !ov_lat_r
      |=> state_r == RPS_SS && cnt_r == 11'h000)
      else $error("soft-start not started when enabled");
   a_shutdown_code: assert property (
      i_por_ok && !ov_lat_r && !i_ov_cmp && i_voltage_code == CODE_OFF
      |=> state_r == RPS_OFF)
      else $error("shutdown code did not stop the controller");
   a_ss_hiz: assert property (
      state_r == RPS_SS && cnt_r < SS_HIZ_END && !i_ov_cmp
      |-> o_phase_oe == PH_NONE && !o_dac_en && o_ref_units == 7'h00)
      else $error("early soft-start not floated");
   a_ss_clamp: assert property (
      i_por_ok && state_r == RPS_SS && cnt_r >= SS_HIZ_END
      && cnt_r < SS_PULSE_START && !i_ov_cmp
      |-> o_phase_oe == PH_ALL && o_phase_out == PH_NONE)
      else $error("soft-start clamp phase not low");
   a_ss_to_run: assert property (
      state_r == RPS_SS && en_all && !i_ov_cmp && !ov_lat_r && !i_oc_cmp
      && i_phase_pulse && cnt_r == SS_LAST |=> state_r == RPS_RUN)
      else $error("soft-start did not end after its last cycle");
   a_ss_no_pg: assert property (
      state_r != RPS_RUN |=> !o_power_good_flag)
      else $error("power good before soft-start end");
   a_ref_step: assert property (
      $past(dac_on) && dac_on && o_ref_units != $past(o_ref_units)
      |-> $past(i_phase_pulse) && $past(step_ph_r)
          && (o_ref_units == $past(o_ref_units) + REF_STEP
              || o_ref_units == $past(o_ref_units) - REF_STEP))
      else $error("reference moved other than one step per two cycles");
   a_oc_hiccup: assert property (
      i_por_ok && !i_ov_cmp && !ov_lat_r && en_all && i_oc_cmp
      && (state_r == RPS_SS || state_r == RPS_RUN)
      |=> state_r == RPS_OCW ##0 o_phase_oe == PH_NONE || i_ov_cmp)
      else $error("overcurrent did not enter hiccup wait");
endmodule

// File: test/rps_far_side.sv
// far-side model: phase clock source and interleaved per-phase comparator results
`timescale 1ns/1ns
module rps_far_side #(
   parameter int PER = 4
) (
   input wire logic i_mclk,
   input wire logic i_rstn,
   output logic o_phase_pulse,
   output logic [2:0] o_pwm_cmd
);
   int cnt_r;
   always @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_r <= 0;
      end else begin
         cnt_r <= (cnt_r == PER - 1) ? 0 : cnt_r + 1;
      end
   end
   // one mclk wide pulse; a short period keeps the 2048-cycle counts cheap
   assign o_phase_pulse = (cnt_r == PER - 1);
   assign o_pwm_cmd = {cnt_r == 2, cnt_r == 1, cnt_r == 0};
endmodule

// File: test/rps_sequencer_tb.sv
// self-checking bench for the regulator sequencer
`timescale 1ns/1ns
module rps_sequencer_tb
   import rps_pkg::*;
;
   logic mclk, rstn, ph, por_ok, en_ok, ov, ov_clr, uv, oc, pg, dac_en, dac_prev;
   logic [4:0] code;
   logic [2:0] pwm, ph_out, ph_oe;
   logic [6:0] ref_u;
   logic [7:0] duty;
   int err_total = 0, checked = 0, seed = 25, last_ref = 0, since = 0, d, keep;
   rps_far_side #(.PER(4)) u_rps_far_side (.i_mclk(mclk), .i_rstn(rstn),
      .o_phase_pulse(ph), .o_pwm_cmd(pwm));
   rps_sequencer u_rps_sequencer (.i_mclk(mclk), .i_rstn(rstn), .i_phase_pulse(ph),
      .i_por_ok(por_ok), .i_en_ok(en_ok), .i_voltage_code(code), .i_ov_cmp(ov),
      .i_ov_clear(ov_clr), .i_uv_cmp(uv), .i_oc_cmp(oc), .i_pwm_cmd(pwm),
      .o_phase_out(ph_out), .o_phase_oe(ph_oe), .o_power_good_flag(pg),
      .o_dac_en(dac_en), .o_ref_units(ref_u), .o_duty_limit(duty));
   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic pulses(input int n);
      repeat (n) @(posedge mclk iff ph);
      #1;
   endtask
   task automatic edge1;
      @(posedge mclk);
      #1;
   endtask
   task automatic done_test(input string name);
      $display("test %s done", name);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // stepper model: while the reference DAC stays enabled, the reference moves one unit per two pulses
   always @(posedge mclk) begin
      if (ph) since++;
      #1;
      if (rstn && dac_en && dac_prev && int'(ref_u) != last_ref) begin
         d = int'(ref_u) - last_ref;
         chk(8'(d * d), 8'h01);
         chk(8'(since >= 2), 8'h01);
         since = 0;
      end
      last_ref = int'(ref_u);
      dac_prev = dac_en;
   end
   // caller sets the last enable condition just after a pulse edge
   task automatic soft_start;
      pulses(int'(SS_HIZ_END) - 1);
      chk(8'(ph_oe), 8'h00);
      chk(8'(dac_en), 8'h00);
      pulses(1);
      chk(8'(dac_en), 8'h01);
      chk(8'(ph_oe), 8'h07);
      chk(8'(ph_out), 8'h00);
      pulses(int'(SS_LOW_CYC) - 1);
      chk(8'(ph_out), 8'h00);
      pulses(1);
      chk(8'(ph_out), 8'(pwm));
      pulses(int'(SS_LAST) - int'(SS_PULSE_START));
      chk(8'(pg), 8'h00);
      pulses(1);
      edge1;
      chk(8'(pg), 8'h01);
      chk(duty, DUTY_MAX);
      chk(8'(ref_u), 8'(REF_TOP_UNITS - 7'(code)));
      done_test("soft-start");
   endtask
   initial begin
      #1200000;
      err_total++;
      wrap_up;
   end
   initial begin
      rstn = 0; por_ok = 0; en_ok = 1; ov = 0; ov_clr = 0; uv = 0; oc = 0;
      code = 5'h0a;
      repeat (10) @(posedge mclk);
      #1 rstn = 1;
      chk(8'(ref_u), 8'h00);
      chk(duty, 8'h00);
      ov = 1;
      #1 chk(8'(ph_oe), 8'h00);
      ov = 0;
      por_ok = 1;
      en_ok = 0;
      pulses(40);
      chk(8'(ph_oe), 8'h00);
      chk(8'(dac_en), 8'h00);
      en_ok = 1;
      soft_start;
      uv = 1;
      edge1;
      chk(8'(pg), 8'h00);
      chk(8'(ph_oe), 8'h07);
      uv = 0;
      edge1;
      chk(8'(pg), 8'h01);
      done_test("undervoltage");
      keep = int'(ref_u);
      pulses(1);
      code = (code == 5'h00) ? 5'h01 : 5'h00;
      edge1;
      code = 5'(REF_TOP_UNITS - 7'(keep));
      pulses(10);
      chk(8'(ref_u), 8'(keep));
      for (int i = 0; i < 5; i++) begin
         pulses(1);
         code = 5'($unsigned($random(seed)) % 31);
         if (i == 1) begin
            pulses(5);
            code = 5'($unsigned($random(seed)) % 31);
         end
         pulses(68);
         chk(8'(ref_u), 8'(REF_TOP_UNITS - 7'(code)));
      end
      done_test("voltage code");
      pulses(1);
      code = CODE_OFF;
      edge1;
      chk(8'(ph_oe), 8'h00);
      pulses(1);
      code = 5'h05;
      soft_start;
      pulses(1);
      oc = 1;
      edge1;
      oc = 0;
      chk(8'(ph_oe), 8'h00);
      chk(8'(pg), 8'h00);
      pulses(int'(OC_WAIT_LAST));
      chk(8'(ph_oe), 8'h00);
      chk(8'(dac_en), 8'h00);
      pulses(1);
      soft_start;
      ov = 1;
      #1 chk(8'(ph_oe), 8'h07);
      chk(8'(ph_out), 8'h00);
      edge1;
      ov = 0;
      ov_clr = 1;
      edge1;
      chk(8'(ph_oe), 8'h00);
      ov = 1;
      #1 chk(8'(ph_oe), 8'h07);
      chk(8'(ph_out), 8'h00);
      edge1;
      ov = 0;
      edge1;
      chk(8'(ph_oe), 8'h00);
      en_ok = 0;
      code = 5'h03;
      pulses(2);
      en_ok = 1;
      pulses(40);
      chk(8'(ph_oe), 8'h00);
      chk(8'(pg), 8'h00);
      por_ok = 0;
      edge1;
      chk(8'(ph_oe), 8'h00);
      ov_clr = 0;
      pulses(1);
      por_ok = 1;
      soft_start;
      done_test("overvoltage");
      wrap_up;
   end
endmodule
